// >>> pts_pkg.sv
// Shared constants and types of the parallel to serial transmitter.
// Assumes a 50 MHz system clock, a free-running transmit clock and a
// boundary-scan test clock, each its own domain.
package pts_pkg;

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  localparam int          WORD_W      = 10;
  localparam int          FRAME_W     = 12;
  localparam logic [9:0]  SYNC_SYMBOL = 10'h3E0;
  localparam logic [9:0]  LFSR_SEED   = 10'h001;
  localparam logic        START_BIT   = 1'b1;
  localparam logic        STOP_BIT    = 1'b0;

  // ----------------------------------------------------------------
  // Timing counts in transmit clock cycles
  // ----------------------------------------------------------------
  localparam logic [2:0]  SYNC_MIN_CYC = 3'h5;
  localparam logic [10:0] LOCK_CYC     = 11'h400;

  // ----------------------------------------------------------------
  // Register map, byte addresses, and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADR_CTRL       = 8'h00;
  localparam logic [7:0]  ADR_STAT       = 8'h04;
  localparam int          CTRL_AT_SPEED_SELF_TEST_BIT  = 0;
  localparam logic [1:0]  CTRL_RST       = 2'h0;
  localparam int          STAT_LOCK_BIT  = 0;
  localparam int          STAT_SYNC_BIT  = 1;
  localparam int          STAT_AT_SPEED_SELF_TEST_BIT  = 2;

  // ----------------------------------------------------------------
  // Test access port instructions
  // ----------------------------------------------------------------
  localparam logic [1:0]  IR_IDCODE  = 2'h1;
  localparam logic [1:0]  IR_RUNBIST = 2'h2;
  localparam logic [1:0]  IR_BYPASS  = 2'h3;
  localparam logic [1:0]  IR_CAPTURE = 2'h1;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pts_wbReq_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } pts_wbRsp_t;

  typedef enum logic [2:0] {
    LK_DOWN = 3'h1,
    LK_LOCK = 3'h2,
    LK_RUN  = 3'h4
  } pts_linkState_t;

  typedef enum logic [15:0] {
    TS_RESET = 16'h0001, TS_IDLE  = 16'h0002, TS_SELDR = 16'h0004,
    TS_CAPDR = 16'h0008, TS_SHDR  = 16'h0010, TS_EX1DR = 16'h0020,
    TS_PADR  = 16'h0040, TS_EX2DR = 16'h0080, TS_UPDR  = 16'h0100,
    TS_SELIR = 16'h0200, TS_CAPIR = 16'h0400, TS_SHIR  = 16'h0800,
    TS_EX1IR = 16'h1000, TS_PAIR  = 16'h2000, TS_EX2IR = 16'h4000,
    TS_UPIR  = 16'h8000
  } pts_tapState_t;

endpackage

// >>> pts_transmitter.sv
// Parallel to serial transmitter: word capture, framing, sync, self-test,
// power-down, output enable, test access port and a register slave.
// Assumes an external multiplying PLL shifts each frame out serially.
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps

module pts_transmitter #(
  parameter logic [31:0] ID_CODE = 32'h00000001 // Arbitrary value.
) (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire pts_pkg::pts_wbReq_t wbReq,
  output pts_pkg::pts_wbRsp_t     wbRsp,
  input  wire logic               transmitClock,
  input  wire logic [9:0]         parallelWordIn,
  input  wire logic               captureEdgeSelect,
  input  wire logic               serialOutputEnable,
  input  wire logic               powerDown_n,
  input  wire logic               syncRequestA,
  input  wire logic               syncRequestB,
  output logic [11:0]             linkFrame,
  output logic                    linkOutEn,
  input  wire logic               tck,
  input  wire logic               trst_n,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdoEn
);

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]             edgeSy;
    logic [1:0]             syncASy;
    logic [1:0]             syncBSy;
    logic [1:0]             oeSy;
    logic [1:0]             pdnSy;
    logic [1:0]             bistSy;
    logic [1:0]             tapBistSy;
    pts_pkg::pts_linkState_t st;
    logic [10:0]            lockCnt;
    logic [2:0]             syncCnt;
    logic                   syncOn;
    logic [9:0]             lfsr;
    logic [11:0]            frame;
    logic                   frameEn;
    logic                   outEn;
  } pts_link_t;

  pts_link_t  lq;
  pts_link_t  ld;
  logic [1:0] linkRstPipe;
  logic       linkRst;
  logic [9:0] fallWord_q;
  logic       syncAny;
  logic       bistOn;
  logic [9:0] word;
  logic       ctrlBist_q;
  logic       tapBist_q;

  // Reset release is synchronised so the link flops leave reset together.
  always_ff @(posedge transmitClock or posedge sys_rst)
  begin
    if (sys_rst)
      linkRstPipe <= 2'h3;
    else
      linkRstPipe <= {linkRstPipe[0], 1'b0};
  end
  assign linkRst = linkRstPipe[1];

  // Falling-edge capture; the rising-edge path samples the pins directly.
  always_ff @(negedge transmitClock or posedge linkRst)
  begin
    if (linkRst)
      fallWord_q <= 10'h000;
    else
      fallWord_q <= parallelWordIn;
  end

  // Frame selection, sync detection, self-test and PLL lock sequencing.
  always_comb
  begin
    ld = lq;
    ld.edgeSy    = {lq.edgeSy[0], captureEdgeSelect};
    ld.syncASy   = {lq.syncASy[0], syncRequestA};
    ld.syncBSy   = {lq.syncBSy[0], syncRequestB};
    ld.oeSy      = {lq.oeSy[0], serialOutputEnable};
    ld.pdnSy     = {lq.pdnSy[0], powerDown_n};
    ld.bistSy    = {lq.bistSy[0], ctrlBist_q};
    ld.tapBistSy = {lq.tapBistSy[0], tapBist_q};
    syncAny = lq.syncASy[1] | lq.syncBSy[1];
    bistOn  = lq.bistSy[1] | lq.tapBistSy[1];
    word    = lq.edgeSy[1] ? parallelWordIn : fallWord_q;
    case (lq.st)
      pts_pkg::LK_DOWN:
      begin
        ld.lockCnt = 11'h000;
        ld.st      = pts_pkg::LK_LOCK;
      end
      pts_pkg::LK_LOCK:
      begin
        ld.lockCnt = lq.lockCnt + 11'h001;
        if (lq.lockCnt == pts_pkg::LOCK_CYC - 11'h001)
          ld.st = pts_pkg::LK_RUN;
      end
      pts_pkg::LK_RUN:
        ld.st = pts_pkg::LK_RUN;
      default:
        ld.st = pts_pkg::LK_DOWN;
    endcase
    if (!lq.pdnSy[1])
    begin
      ld.st      = pts_pkg::LK_DOWN;
      ld.lockCnt = 11'h000;
    end
    // The count saturates so a long request never wraps back to zero.
    if (!syncAny)
      ld.syncCnt = 3'h0;
    else if (lq.syncCnt != pts_pkg::SYNC_MIN_CYC)
      ld.syncCnt = lq.syncCnt + 3'h1;
    ld.syncOn = syncAny && (ld.syncCnt == pts_pkg::SYNC_MIN_CYC);
    if (bistOn && lq.st == pts_pkg::LK_RUN)
      ld.lfsr = {lq.lfsr[8:0], lq.lfsr[9] ^ lq.lfsr[6]};
    // Start high and stop low make an edge in every frame for recovery.
    if (ld.syncOn)
      ld.frame = {pts_pkg::START_BIT, pts_pkg::SYNC_SYMBOL,
                  pts_pkg::STOP_BIT};
    else if (bistOn)
      ld.frame = {pts_pkg::START_BIT, lq.lfsr, pts_pkg::STOP_BIT};
    else
      ld.frame = {pts_pkg::START_BIT, word, pts_pkg::STOP_BIT};
    if (lq.st != pts_pkg::LK_RUN)
      ld.frame = 12'h000;
    ld.frameEn = (lq.st == pts_pkg::LK_RUN);
    ld.outEn   = lq.oeSy[1] && lq.pdnSy[1]
                 && (lq.st == pts_pkg::LK_RUN);
  end

  // One register for the whole link state.
  always_ff @(posedge transmitClock or posedge linkRst)
  begin
    if (linkRst)
    begin
      lq      <= '0;
      lq.st   <= pts_pkg::LK_DOWN;
      lq.lfsr <= pts_pkg::LFSR_SEED;
    end
    else
      lq <= ld;
  end

  assign linkFrame = lq.frame;
  assign linkOutEn = lq.outEn;

  a_sync_start: assert property (@(posedge transmitClock) disable iff
    (linkRst) $rose(lq.syncOn) |-> $past(syncAny, 1) && $past(syncAny, 5))
    else $error("Sync pattern began before five request cycles.");
  a_sync_held: assert property (@(posedge transmitClock) disable iff
    (linkRst) lq.syncOn && syncAny |=> lq.syncOn)
    else $error("Sync pattern stopped while still requested.");
  a_sync_replaces: assert property (@(posedge transmitClock) disable iff
    (linkRst) lq.syncOn && lq.frameEn
    |-> lq.frame[10:1] == pts_pkg::SYNC_SYMBOL)
    else $error("Data sent while sync pattern was due.");
  a_frame_edge: assert property (@(posedge transmitClock) disable iff
    (linkRst) lq.frameEn |-> lq.frame[11] != lq.frame[0])
    else $error("Frame without a transition.");
  a_oe_off: assert property (@(posedge transmitClock) disable iff
    (linkRst) !lq.oeSy[1] |=> !linkOutEn)
    else $error("Serial outputs driven while disabled.");
  a_pdn_sleep: assert property (@(posedge transmitClock) disable iff
    (linkRst) !lq.pdnSy[1] |=> lq.st == pts_pkg::LK_DOWN && !linkOutEn)
    else $error("Power-down did not stop the link.");
  a_lock_wait: assert property (@(posedge transmitClock) disable iff
    (linkRst) lq.st == pts_pkg::LK_LOCK |=> !lq.frameEn)
    else $error("Frame sent before the PLL relocked.");
  a_word_capture: assert property (@(posedge transmitClock) disable iff
    (linkRst) lq.st == pts_pkg::LK_RUN && !syncAny && !bistOn
    && lq.edgeSy[1] |=> lq.frame[10:1] == $past(parallelWordIn))
    else $error("Captured word not carried into the frame.");

  // ----------------------------------------------------------------
  // System domain register slave
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [1:0]  ctrl;
    logic [2:0]  statSy0;
    logic [2:0]  statSy1;
  } pts_sys_t;

  pts_sys_t sq;
  pts_sys_t sd;
  logic     wbHit;

  // Ack follows one cycle after the request and drops straight after.
  always_comb
  begin
    sd = sq;
    sd.statSy0 = {bistOn & lq.frameEn, lq.syncOn, lq.frameEn};
    sd.statSy1 = sq.statSy0;
    wbHit  = wbReq.cyc && wbReq.stb && !sq.ack;
    sd.ack = wbHit;
    sd.rdat = 32'h00000000;
    if (wbHit && wbReq.we && wbReq.sel[0] && wbReq.adr == pts_pkg::ADR_CTRL)
      sd.ctrl = wbReq.dat[1:0];
    if (wbHit && !wbReq.we && wbReq.adr == pts_pkg::ADR_CTRL)
      sd.rdat = {30'h00000000, sq.ctrl};
    if (wbHit && !wbReq.we && wbReq.adr == pts_pkg::ADR_STAT)
      sd.rdat = {29'h00000000, sq.statSy1};
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sq      <= '0;
      sq.ctrl <= pts_pkg::CTRL_RST;
    end
    else
      sq <= sd;
  end

  assign ctrlBist_q = sq.ctrl[pts_pkg::CTRL_AT_SPEED_SELF_TEST_BIT];
  assign wbRsp.ack  = sq.ack;
  assign wbRsp.dat  = sq.rdat;

  a_wb_ack: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wbReq.cyc && wbReq.stb && !sq.ack |=> sq.ack ##1 !sq.ack)
    else $error("Bus answer not a single cycle after request.");

  // ----------------------------------------------------------------
  // Test access port, test clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    pts_pkg::pts_tapState_t st;
    logic [1:0]             ir;
    logic [1:0]             irSh;
    logic [31:0]            dr;
    logic                   tdo;
    logic                   tdoEn;
    logic                   at_speed_self_test;
  } pts_tap_t;

  pts_tap_t tq;
  pts_tap_t td;

  // Standard sixteen-state controller with bypass, id and self-test.
  always_comb
  begin
    td = tq;
    case (tq.st)
      pts_pkg::TS_RESET: td.st = tms ? pts_pkg::TS_RESET : pts_pkg::TS_IDLE;
      pts_pkg::TS_IDLE:  td.st = tms ? pts_pkg::TS_SELDR : pts_pkg::TS_IDLE;
      pts_pkg::TS_SELDR: td.st = tms ? pts_pkg::TS_SELIR : pts_pkg::TS_CAPDR;
      pts_pkg::TS_CAPDR: td.st = tms ? pts_pkg::TS_EX1DR : pts_pkg::TS_SHDR;
      pts_pkg::TS_SHDR:  td.st = tms ? pts_pkg::TS_EX1DR : pts_pkg::TS_SHDR;
      pts_pkg::TS_EX1DR: td.st = tms ? pts_pkg::TS_UPDR  : pts_pkg::TS_PADR;
      pts_pkg::TS_PADR:  td.st = tms ? pts_pkg::TS_EX2DR : pts_pkg::TS_PADR;
      pts_pkg::TS_EX2DR: td.st = tms ? pts_pkg::TS_UPDR  : pts_pkg::TS_SHDR;
      pts_pkg::TS_UPDR:  td.st = tms ? pts_pkg::TS_SELDR : pts_pkg::TS_IDLE;
      pts_pkg::TS_SELIR: td.st = tms ? pts_pkg::TS_RESET : pts_pkg::TS_CAPIR;
      pts_pkg::TS_CAPIR: td.st = tms ? pts_pkg::TS_EX1IR : pts_pkg::TS_SHIR;
      pts_pkg::TS_SHIR:  td.st = tms ? pts_pkg::TS_EX1IR : pts_pkg::TS_SHIR;
      pts_pkg::TS_EX1IR: td.st = tms ? pts_pkg::TS_UPIR  : pts_pkg::TS_PAIR;
      pts_pkg::TS_PAIR:  td.st = tms ? pts_pkg::TS_EX2IR : pts_pkg::TS_PAIR;
      pts_pkg::TS_EX2IR: td.st = tms ? pts_pkg::TS_UPIR  : pts_pkg::TS_SHIR;
      pts_pkg::TS_UPIR:  td.st = tms ? pts_pkg::TS_SELDR : pts_pkg::TS_IDLE;
      default:           td.st = pts_pkg::TS_RESET;
    endcase
    case (tq.st)
      pts_pkg::TS_RESET: td.ir = pts_pkg::IR_IDCODE;
      pts_pkg::TS_CAPIR: td.irSh = pts_pkg::IR_CAPTURE;
      pts_pkg::TS_SHIR:  td.irSh = {tdi, tq.irSh[1]};
      pts_pkg::TS_UPIR:  td.ir = tq.irSh;
      pts_pkg::TS_CAPDR:
        td.dr = (tq.ir == pts_pkg::IR_IDCODE) ? ID_CODE : 32'h00000000;
      pts_pkg::TS_SHDR:
        if (tq.ir == pts_pkg::IR_IDCODE)
          td.dr = {tdi, tq.dr[31:1]};
        else
          td.dr = {31'h00000000, tdi};
      default: td.dr = tq.dr;
    endcase
    td.tdoEn = (tq.st == pts_pkg::TS_SHDR) || (tq.st == pts_pkg::TS_SHIR);
    td.tdo   = (tq.st == pts_pkg::TS_SHIR) ? tq.irSh[0] : tq.dr[0];
    td.at_speed_self_test  = (tq.ir == pts_pkg::IR_RUNBIST)
               && (tq.st == pts_pkg::TS_IDLE);
  end

  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tq    <= '0;
      tq.st <= pts_pkg::TS_RESET;
      tq.ir <= pts_pkg::IR_IDCODE;
    end
    else
      tq <= td;
  end

  assign tapBist_q = tq.at_speed_self_test;
  assign tdo       = tq.tdo;
  assign tdoEn     = tq.tdoEn;

  a_tap_reset: assert property (@(posedge tck) disable iff (!trst_n)
    tms [*5] |=> tq.st == pts_pkg::TS_RESET)
    else $error("Five high mode cycles did not reset the port.");

endmodule

// >>> pts_link_rx.sv
// Receiving end of the serial link: checks every driven frame.
// Assumes frames change on the rising edge of transmitClock.
`timescale 1ns/1ps

module pts_link_rx (
  input  wire logic        transmitClock,
  input  wire logic [11:0] linkFrame,
  input  wire logic        linkOutEn,
  output int               frameCount,
  output int               badFrames,
  output int               syncFrames
);
  // ----------------------------------------------------------------
  // Frame check
  // ----------------------------------------------------------------
  initial
  begin
    frameCount = 0;
    badFrames = 0;
    syncFrames = 0;
  end

  // Sampled mid-cycle so a frame is never read while it changes.
  // A high start and low stop bit give the receiver an edge in every
  // frame, whatever the payload holds.
  always @(negedge transmitClock)
  begin
    if (linkOutEn === 1'b1)
    begin
      frameCount++;
      if (linkFrame[11] !== 1'b1 || linkFrame[0] !== 1'b0)
        badFrames++;
      if (linkFrame[10:1] === pts_pkg::SYNC_SYMBOL)
        syncFrames++;
    end
  end
endmodule

// >>> pts_transmitter_tb.sv
// Testbench of the transmitter: register bus, link words, sync, enable,
// self-test, power-down and the test access port.
// Assumes the package, the design and the receiving model are compiled.
`timescale 1ns/1ps

module pts_transmitter_tb;
  localparam logic [31:0] TB_ID = 32'h1A5C3E01; // Arbitrary value.
  // Mode bits, one per test clock, that walk from shift-DR through the
  // instruction path and park the port in idle.
  localparam logic [9:0]  IR_WALK = 10'h18F;

  logic                clk_sys = 1'b0;
  logic                sys_rst = 1'b1;
  logic                transmitClock = 1'b0;
  logic                tck = 1'b0;
  logic                trst_n = 1'b0;
  logic                tms = 1'b1;
  logic                tdi = 1'b0;
  logic                tdo;
  logic                tdoEn;
  pts_pkg::pts_wbReq_t wbReq = '0;
  pts_pkg::pts_wbRsp_t wbRsp;
  logic [9:0]          parallelWordIn = 10'h000;
  logic                captureEdgeSelect = 1'b1;
  logic                serialOutputEnable = 1'b1;
  logic                powerDown_n = 1'b1;
  logic                syncRequestA = 1'b0;
  logic                syncRequestB = 1'b0;
  logic [11:0]         linkFrame;
  logic                linkOutEn;
  int                  frameCount;
  int                  badFrames;
  int                  syncFrames;
  int                  errors = 0;
  int                  checkCount = 0;
  logic [31:0]         rd;
  logic [31:0]         idBits;
  logic [9:0]          words [8] = '{10'h000, 10'h3FF, 10'h2A5, 10'h15A,
                                     10'h001, 10'h200, 10'h0F0, 10'h30C};

  // Three unrelated clocks; the link clock is offset in phase.
  always #10 clk_sys = ~clk_sys;
  always #50 tck = ~tck;
  initial
  begin
    #7;
    forever #24 transmitClock = ~transmitClock;
  end

  pts_transmitter #(.ID_CODE(TB_ID)) pts_transmitter_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp),
    .transmitClock(transmitClock), .parallelWordIn(parallelWordIn),
    .captureEdgeSelect(captureEdgeSelect),
    .serialOutputEnable(serialOutputEnable), .powerDown_n(powerDown_n),
    .syncRequestA(syncRequestA), .syncRequestB(syncRequestB),
    .linkFrame(linkFrame), .linkOutEn(linkOutEn), .tck(tck),
    .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn));

  pts_link_rx pts_link_rx_i (
    .transmitClock(transmitClock), .linkFrame(linkFrame),
    .linkOutEn(linkOutEn), .frameCount(frameCount),
    .badFrames(badFrames), .syncFrames(syncFrames));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  // No answer time is assumed: only the watchdog ends a hung wait.
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [3:0] sel, input logic [31:0] wd);
    @(posedge clk_sys);
    wbReq <= {1'b1, 1'b1, we, adr, sel, wd};
    do
    begin
      @(posedge clk_sys);
    end
    while (wbRsp.ack !== 1'b1);
    rd = wbRsp.dat;
    wbReq <= '0;
  endtask

  task automatic lk(input int n);
    repeat (n) @(posedge transmitClock);
  endtask

  // Polls status until the link reports running, with a bound.
  task automatic waitLock();
    int n;
    n = 0;
    do
    begin
      wb(1'b0, pts_pkg::ADR_STAT, 4'hF, '0);
      n++;
    end
    while (rd[pts_pkg::STAT_LOCK_BIT] !== 1'b1 && n < 3000);
    lk(4);
    #1;
    chk(32'(linkOutEn), 32'h1);
  endtask

  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, checkCount);
    if (errors == 0 && checkCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    int n;
    repeat (3) @(posedge clk_sys);
    chk(32'({wbRsp.ack, linkOutEn, linkFrame}), 32'h0);
    sys_rst <= 1'b0;
    trst_n <= 1'b1;
    wb(1'b0, pts_pkg::ADR_CTRL, 4'hF, '0);
    chk(rd, 32'(pts_pkg::CTRL_RST));
    wb(1'b1, pts_pkg::ADR_CTRL, 4'h0, 32'h3);
    wb(1'b0, pts_pkg::ADR_CTRL, 4'hF, '0);
    chk(rd, 32'(pts_pkg::CTRL_RST));
    wb(1'b1, pts_pkg::ADR_CTRL, 4'hF, 32'h2);
    wb(1'b0, pts_pkg::ADR_CTRL, 4'hF, '0);
    chk(rd, 32'h2);
    wb(1'b1, 8'h08, 4'hF, 32'hFFFF);
    wb(1'b0, 8'h08, 4'hF, '0);
    chk(rd, 32'h0);
    waitLock();
    wb(1'b1, pts_pkg::ADR_STAT, 4'hF, 32'h6);
    wb(1'b0, pts_pkg::ADR_STAT, 4'hF, '0);
    chk(rd, 32'h1);
    // A new word every cycle, on both capture edges; each frame shows
    // the word driven one link edge earlier.
    for (int s = 1; s >= 0; s--)
    begin
      @(posedge transmitClock);
      captureEdgeSelect <= s[0];
      lk(6);
      for (int i = 0; i < 10; i++)
      begin
        @(posedge transmitClock);
        parallelWordIn <= words[i % 8];
        #1;
        if (i >= 1)
          chk(32'(linkFrame), {20'h0, 1'b1, words[(i - 1) % 8], 1'b0});
      end
    end
    // Four cycles of request are one too few to start syncing.
    @(posedge transmitClock);
    parallelWordIn <= 10'h155;
    syncRequestA <= 1'b1;
    lk(4);
    syncRequestA <= 1'b0;
    lk(8);
    chk(syncFrames, 32'h0);
    syncRequestB <= 1'b1;
    lk(16);
    #1;
    chk(32'(linkFrame), {20'h0, 1'b1, pts_pkg::SYNC_SYMBOL, 1'b0});
    chk(32'(syncFrames > 6), 32'h1);
    @(posedge transmitClock);
    syncRequestB <= 1'b0;
    lk(8);
    #1;
    chk(32'(linkFrame), {20'h0, 1'b1, 10'h155, 1'b0});
    @(posedge transmitClock);
    serialOutputEnable <= 1'b0;
    lk(5);
    #1;
    chk(32'(linkOutEn), 32'h0);
    @(posedge transmitClock);
    serialOutputEnable <= 1'b1;
    // Self-test replaces the steady data word with its own pattern.
    wb(1'b1, pts_pkg::ADR_CTRL, 4'hF, 32'h1);
    lk(6);
    #1;
    chk(32'(linkFrame[10:1] !== 10'h155), 32'h1);
    wb(1'b0, pts_pkg::ADR_STAT, 4'hF, '0);
    chk(32'(rd[pts_pkg::STAT_AT_SPEED_SELF_TEST_BIT]), 32'h1);
    wb(1'b1, pts_pkg::ADR_CTRL, 4'hF, 32'h0);
    @(posedge transmitClock);
    powerDown_n <= 1'b0;
    lk(6);
    #1;
    chk(32'({linkOutEn, linkFrame}), 32'h0);
    @(posedge transmitClock);
    powerDown_n <= 1'b1;
    lk(200);
    #1;
    chk(32'({linkOutEn, linkFrame}), 32'h0);
    waitLock();
    // Walk to Shift-DR and read the identity register, LSB first.
    chk(32'(tdoEn), 32'h0);
    n = 0;
    for (int k = 0; k < 42; k++)
    begin
      @(posedge tck);
      tms <= (k == 1);
      if (tdoEn === 1'b1 && n < 32)
      begin
        idBits = {tdo, idBits[31:1]};
        n++;
      end
    end
    chk(idBits, TB_ID);
    // Shift the self-test instruction in, LSB first, then rest in idle.
    for (int k = 0; k < 10; k++)
    begin
      @(posedge tck);
      tms <= IR_WALK[k];
      tdi <= (k == 7);
    end
    repeat (6) @(posedge tck);
    wb(1'b0, pts_pkg::ADR_STAT, 4'hF, '0);
    chk(rd, 32'h5);
    chk(badFrames, 32'h0);
    chk(32'(frameCount > 100), 32'h1);
    final_report();
  end

  // Each lock wait takes about 50 us; this bound leaves a wide margin.
  initial
  begin
    #400us;
    errors++;
    final_report();
  end
endmodule
